/* File: ipf_pkg.sv */
// Constants and types shared by the inverter gate-drive controller.
package ipfc_pkg;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int DEAD_TIME_NS    = 1000;
  localparam int MIN_PULSE_NS    = 700;
  localparam int DEAD_CYCLES     = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PULSE_CYCLES = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 8;
  localparam int NUM_PHASES      = 3;

  typedef enum logic [2:0] {
    PH_OFF  = 3'h1,
    PH_HIGH = 3'h2,
    PH_LOW  = 3'h4
  } ipfc_phase_e;

  typedef struct packed {
    logic [NUM_PHASES-1:0] highIn;
    logic [NUM_PHASES-1:0] lowIn;
  } ipfc_gates_s;
endpackage

/* File: ipfc_ctrl.sv */
// Gate-drive controller that feeds the power module and watches its fault line.
`timescale 1ns/1ns
`default_nettype none
module ipfc_ctrl
  import ipfc_pkg::*;
#(
  parameter int DEAD_CNT  = DEAD_CYCLES,
  parameter int PULSE_CNT = MIN_PULSE_CYCLES
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic [NUM_PHASES-1:0] cmdHigh,
  input  wire logic [NUM_PHASES-1:0] cmdLow,
  input  wire logic                  faultIn,
  output logic                       faultOutEnN,
  output logic                       faultActive,
  output ipfc_gates_s                gates
);
  localparam logic [CNT_W-1:0] RUN_MAX = '1;

  // Both intervals live in CNT_W-bit counters; zero would drop the interval altogether.
  if (DEAD_CNT < 1 || DEAD_CNT > RUN_MAX ||
      PULSE_CNT < 1 || PULSE_CNT > RUN_MAX) begin : gBadCounts
    $error("Counts out of range");
  end

  // The fault pin is only sensed; the module sinks it, so our driver stays released.
  assign faultOutEnN = 1'h1;

  logic [2:0] faultSync_q;
  logic [2:0] faultSync_d;
  logic       fault_q;
  logic       fault_d;

  always_comb begin
    faultSync_d = {faultSync_q[1:0], faultIn};
    fault_d     = fault_q;
    // Change counts only when the second and third stages agree, rejecting glitches.
    if (faultSync_q[1] == faultSync_q[2]) begin
      fault_d = ~faultSync_q[2];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      faultSync_q <= 3'h7;
      fault_q     <= 1'h0;
    end else begin
      faultSync_q <= faultSync_d;
      fault_q     <= fault_d;
    end
  end

  assign faultActive = fault_q;

  logic [NUM_PHASES-1:0] gateHigh;
  logic [NUM_PHASES-1:0] gateLow;

  genvar g;
  generate
    for (g = 0; g < NUM_PHASES; g++) begin : gPhase
      ipfc_phase_e       state_q;
      ipfc_phase_e       state_d;
      logic [CNT_W-1:0]  cnt_q;
      logic [CNT_W-1:0]  cnt_d;
      logic              wantHigh;
      logic              wantLow;
      logic [CNT_W-1:0]  onRun_q;
      logic [CNT_W-1:0]  onRun_d;
      logic [CNT_W-1:0]  offRun_q;
      logic [CNT_W-1:0]  offRun_d;

      // Simultaneous requests resolve to off, the safe state.
      assign wantHigh = cmdHigh[g] & ~cmdLow[g] & ~fault_q;
      assign wantLow  = cmdLow[g] & ~cmdHigh[g] & ~fault_q;

      always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 8'h01;
        end
        case (state_q)
          PH_OFF: begin
            // Off holds for the longer of the dead time and the minimum off pulse.
            if (cnt_q == '0 && wantHigh) begin
              state_d = PH_HIGH;
              cnt_d   = CNT_W'(PULSE_CNT);
            end else if (cnt_q == '0 && wantLow) begin
              state_d = PH_LOW;
              cnt_d   = CNT_W'(PULSE_CNT);
            end
          end
          PH_HIGH: begin
            // A fault cuts the pulse at once; protection outranks pulse width.
            if (fault_q || (cnt_q == '0 && !wantHigh)) begin
              state_d = PH_OFF;
              cnt_d   = CNT_W'(DEAD_CNT > PULSE_CNT ? DEAD_CNT : PULSE_CNT);
            end
          end
          PH_LOW: begin
            if (fault_q || (cnt_q == '0 && !wantLow)) begin
              state_d = PH_OFF;
              cnt_d   = CNT_W'(DEAD_CNT > PULSE_CNT ? DEAD_CNT : PULSE_CNT);
            end
          end
          default: begin
            state_d = PH_OFF;
            cnt_d   = '0;
          end
        endcase
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          state_q <= PH_OFF;
          cnt_q   <= 8'h00;
        end else begin
          state_q <= state_d;
          cnt_q   <= cnt_d;
        end
      end

      assign gateHigh[g] = (state_q == PH_HIGH);
      assign gateLow[g]  = (state_q == PH_LOW);

      // Run lengths of the on and off intervals; they feed only the checks below.
      always_comb begin
        onRun_d  = '0;
        offRun_d = '0;
        if (state_q == PH_OFF) begin
          offRun_d = offRun_q;
          if (offRun_q != RUN_MAX) begin
            offRun_d = offRun_q + 8'h01;
          end
        end else begin
          onRun_d = onRun_q;
          if (onRun_q != RUN_MAX) begin
            onRun_d = onRun_q + 8'h01;
          end
        end
      end

      // Reset counts as a long rest, so the first turn-on after it is legal at once.
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          onRun_q  <= 8'h00;
          offRun_q <= RUN_MAX;
        end else begin
          onRun_q  <= onRun_d;
          offRun_q <= offRun_d;
        end
      end

      property p_no_shoot;
        @(posedge sys_clk) disable iff (!nrst) !(gateHigh[g] && gateLow[g]);
      endproperty
      a_no_shoot: assert property (p_no_shoot) else $error("Both switches on");

      property p_dead;
        @(posedge sys_clk) disable iff (!nrst)
          $rose(gateHigh[g]) |-> offRun_q >= DEAD_CNT;
      endproperty
      a_dead: assert property (p_dead) else $error("Dead time short");

      property p_dead_low;
        @(posedge sys_clk) disable iff (!nrst)
          $rose(gateLow[g]) |-> offRun_q >= DEAD_CNT;
      endproperty
      a_dead_low: assert property (p_dead_low) else $error("Dead time short");

      property p_min_on;
        @(posedge sys_clk) disable iff (!nrst)
          ($fell(gateHigh[g]) || $fell(gateLow[g])) && !$past(fault_q) |-> onRun_q >= PULSE_CNT;
      endproperty
      a_min_on: assert property (p_min_on) else $error("On pulse short");

      property p_fault_off;
        @(posedge sys_clk) disable iff (!nrst)
          fault_q |=> !gateHigh[g] && !gateLow[g];
      endproperty
      a_fault_off: assert property (p_fault_off) else $error("Gate on in fault");

      property p_no_rise_fault;
        @(posedge sys_clk) disable iff (!nrst)
          $rose(gateHigh[g]) || $rose(gateLow[g]) |-> !$past(fault_q);
      endproperty
      a_no_rise_fault: assert property (p_no_rise_fault) else $error("Turn-on in fault");

      property p_min_off;
        @(posedge sys_clk) disable iff (!nrst)
          ($rose(gateHigh[g]) || $rose(gateLow[g])) |-> offRun_q >= PULSE_CNT;
      endproperty
      a_min_off: assert property (p_min_off) else $error("Off pulse short");

      property p_follow;
        @(posedge sys_clk) disable iff (!nrst)
          gateHigh[g] && cnt_q == '0 && !cmdHigh[g] |=> !gateHigh[g];
      endproperty
      a_follow: assert property (p_follow) else $error("Gate ignores command");

      c_high: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(gateHigh[g]));
      c_low: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(gateLow[g]));
      c_cut: cover property (@(posedge sys_clk) disable iff (!nrst) gateLow[g] && fault_q);
    end
  endgenerate

  property p_fault_sync;
    @(posedge sys_clk) disable iff (!nrst)
      $fell(faultIn) ##1 !faultIn [*4] |-> fault_q;
  endproperty
  a_fault_sync: assert property (p_fault_sync) else $error("Fault not seen");

  c_fault: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(fault_q));

  ipfc_gates_s gates_d;

  // The lower gates drop with the synchronised fault itself, one cycle ahead of the state.
  always_comb begin
    gates_d.highIn = gateHigh;
    gates_d.lowIn  = gateLow & ~{NUM_PHASES{fault_q}};
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gates <= '0;
    end else begin
      gates <= gates_d;
    end
  end
endmodule
`default_nettype wire

/* File: ipfc_power_model.sv */
// Behavioural power module: lower-gate gating on trips and an open-drain fault line.
`timescale 1ns/1ns
`default_nettype none
module ipfc_power_model
  import ipfc_pkg::*;
#(
  // Fault pulse length in clock cycles: twenty microseconds at the 10 ns clock.
  parameter int FAULT_CYC = 2000
) (
  input  wire logic                  sys_clk,
  input  wire ipfc_gates_s           gatesIn,
  input  wire logic [2:0]            tripIn,
  input  wire logic [NUM_PHASES-1:0] highUvIn,
  output logic                       faultPullLow,
  output logic [NUM_PHASES-1:0]      swHigh,
  output logic [NUM_PHASES-1:0]      swLow
);
  int unsigned           foCnt = 0;
  logic [NUM_PHASES-1:0] armH  = '0;
  logic [NUM_PHASES-1:0] armL  = '0;
  logic [NUM_PHASES-1:0] prevH = '0;
  logic [NUM_PHASES-1:0] prevL = '0;
  // Bit 0 is a short, bit 1 lower supply loss, bit 2 overheat.
  assign faultPullLow = (foCnt != 0) || tripIn[1] || tripIn[2];
  assign swHigh = armH & gatesIn.highIn;
  assign swLow = armL & gatesIn.lowIn;
  always @(posedge sys_clk) begin
    if (tripIn != 3'h0) begin
      foCnt <= FAULT_CYC;
    end else if (foCnt != 0) begin
      foCnt <= foCnt - 1;
    end
    armH <= ~highUvIn & (armH | (gatesIn.highIn & ~prevH));
    // Lower switches stay disarmed until the pulse ends and a fresh rising input arrives.
    armL <= (faultPullLow || tripIn[0]) ? '0 : (armL | (gatesIn.lowIn & ~prevL));
    prevH <= gatesIn.highIn;
    prevL <= gatesIn.lowIn;
  end
endmodule
`default_nettype wire

/* File: test_ipfc_ctrl.sv */
// Self-checking bench for the gate-drive controller with a power module model.
`timescale 1ns/1ns
`default_nettype none
module test_ipfc_ctrl
  import ipfc_pkg::*;
;
  logic                  sys_clk = 1'b0;
  logic                  nrst = 1'b0;
  logic [NUM_PHASES-1:0] cmdHigh = '0;
  logic [NUM_PHASES-1:0] cmdLow = '0;
  logic [2:0]            trip = '0;
  logic                  faultOutEnN;
  logic                  faultActive;
  logic                  faultPullLow;
  logic [NUM_PHASES-1:0] swHigh;
  logic [NUM_PHASES-1:0] swLow;
  wire logic             faultLine;
  ipfc_gates_s           gates;
  logic [5:0]            v;
  logic [6:0]            noteQ[$];
  int                    n_errors = 0;
  int                    num_checks = 0;
  int                    ph;
  event                  sample;
  // The external pull-up wins unless some party sinks the line.
  assign faultLine = !(faultPullLow || !faultOutEnN);
  initial forever #5 sys_clk = ~sys_clk;
  ipfc_ctrl #(.DEAD_CNT(4), .PULSE_CNT(3)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .cmdHigh(cmdHigh), .cmdLow(cmdLow), .faultIn(faultLine),
    .faultOutEnN(faultOutEnN), .faultActive(faultActive), .gates(gates));
  ipfc_power_model #(.FAULT_CYC(2000)) pm (.sys_clk(sys_clk), .gatesIn(gates), .tripIn(trip),
    .highUvIn(3'h0), .faultPullLow(faultPullLow), .swHigh(swHigh), .swLow(swLow));
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic note(input logic [6:0] exp);
    noteQ.push_back(exp);
    ->sample;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial forever begin
    @(sample);
    num_checks++;
    if (noteQ[0] !== {faultActive, gates}) begin
      n_errors++;
      $display("wrong value outputs expected %h seen %h", noteQ[0], {faultActive, gates});
    end
    num_checks++;
    if ((swHigh & swLow) !== 3'h0) begin
      n_errors++;
      $display("wrong value switches expected %h seen %h", 3'h0, swHigh & swLow);
    end
    void'(noteQ.pop_front());
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hBBB4));
    step(6);
    nrst = 1'b1;
    note(7'h00);
    for (int k = 0; k < 6; k++) begin
      ph = $urandom_range(2, 0);
      v = 6'(k[0] ? 1 << ph : 8 << ph);
      {cmdHigh, cmdLow} = v;
      step(3);
      note({1'b0, v});
      {cmdHigh, cmdLow} = 6'h00;
      step(8);
      cmdHigh[ph] = 1'b1;
      cmdLow[ph] = 1'b1;
      step(4);
      note(7'h00);
      {cmdHigh, cmdLow} = 6'h00;
      step(8);
    end
    $display("test pulses done");
    cmdHigh[ph] = 1'b1;
    step(8);
    cmdHigh[ph] = 1'b0;
    cmdLow[ph] = 1'b1;
    step(3);
    note(7'h00);
    step(10);
    note(7'(1 << ph));
    cmdLow[ph] = 1'b0;
    step(10);
    $display("test dead time done");
    for (int k = 0; k < 3; k++) begin
      cmdLow[ph] = 1'b1;
      step(4);
      note(7'(1 << ph));
      trip[k] = 1'b1;
      step(10);
      note(7'h40);
      {cmdHigh, cmdLow} = 6'(8 << ph);
      trip = 3'h0;
      step(10);
      note(7'h40);
      cmdHigh = 3'h0;
      step(2010);
      note(7'h00);
      step(8);
    end
    $display("test faults done");
    cmdHigh[ph] = 1'b1;
    step(5);
    nrst = 1'b0;
    step(1);
    note(7'h00);
    nrst = 1'b1;
    cmdHigh = 3'h0;
    step(6);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
